// *** rtl/sfp_pkg.sv ***
// Shared constants and types of the synchronous byte FIFO port, device and controller ends
// Behaviour
// - Synchronous FIFO mode only on first channel
// - Enter mode: config selects FIFO, then command
// - Second channel unavailable while mode active
// - All transfers on interface clock rising edge
// - Device drives data bus only while OE low
// - Receive flag low when data; no reads otherwise
// - Byte read when receive flag and RD low
// - Controller lowers OE one period before RD
// - Transmit flag low when room; no writes otherwise
// - Byte written when transmit flag and WR low
// - RD low presents receive head byte on bus
// - Device generates the interface clock output
// - Next receive byte each cycle while RD low
// - Send-immediate strobe raises SEND_NOW while powered, WAKE_REQ while not
package sfp_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_HZ         = 100_000_000;
	localparam int IFACE_CLK_HZ   = 60_000_000;
	// Far end must see each level for a few samples through its synchroniser
	localparam int IFACE_HALF_MIN = 4;
	localparam int IFACE_HALF_RAW = CLK_HZ / (2 * IFACE_CLK_HZ);
	localparam int IFACE_HALF_CYC = (IFACE_HALF_RAW < IFACE_HALF_MIN) ?
		IFACE_HALF_MIN : IFACE_HALF_RAW;

	// ==========================================================
	// Widths, depths, reset values
	localparam int         BUS_W       = 8;
	localparam int         BUF_DEPTH   = 2;
	localparam int         SYNC_STAGES = 3;
	localparam logic       CHAN_FIRST  = 1'b0;
	localparam logic       PIN_IDLE    = 1'b1;
	localparam logic [7:0] BUS_PULL    = 8'hff;

	// ==========================================================
	// State machines
	typedef enum logic [1:0] {
		MODE_OFF  = 2'b01,
		MODE_SYNC = 2'b10
	} sfp_mode_t;

	typedef enum logic [3:0] {
		HS_IDLE  = 4'b0001,
		HS_TURN  = 4'b0010,
		HS_READ  = 4'b0100,
		HS_WRITE = 4'b1000
	} sfp_hstate_t;

endpackage

// *** rtl/sfp_if.sv ***
// Link between device end and controller end, with bus resolution
`timescale 1ns/1ps
`default_nettype none
interface sfp_if;
	import sfp_pkg::*;

	logic               iface_clk;
	logic               rx_avail_n;
	logic               tx_space_n;
	logic               rd_n;
	logic               wr_n;
	logic               oe_n;
	logic               send_now_wake_n;
	logic               powered_config_n;
	logic [BUS_W-1:0]   dev_dout;
	logic               dev_doe;
	logic [BUS_W-1:0]   host_dout;
	logic               host_doe;
	logic [BUS_W-1:0]   fifo_data_bus;

	// Undriven bus reads as pulled high
	assign fifo_data_bus = dev_doe ? dev_dout : (host_doe ? host_dout : BUS_PULL);

	modport dev (
		output iface_clk, rx_avail_n, tx_space_n, powered_config_n, dev_dout, dev_doe,
		input  rd_n, wr_n, oe_n, send_now_wake_n, fifo_data_bus
	);

	modport host (
		input  iface_clk, rx_avail_n, tx_space_n, powered_config_n, fifo_data_bus,
		output rd_n, wr_n, oe_n, send_now_wake_n, host_dout, host_doe
	);

endinterface
`default_nettype wire

// *** rtl/sfp_device.sv ***
// Device end of the synchronous byte FIFO port, with its two-entry receive and transmit buffers
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Two-entry style buffer, flip-flop storage
module sfp_buf
	import sfp_pkg::*;
#(
	parameter int W     = BUS_W,
	parameter int DEPTH = BUF_DEPTH
) (
	input  wire logic                         clk,
	input  wire logic                         rst,
	input  wire logic                         in_valid,
	output logic                              in_ready,
	input  wire logic [W-1:0]                 in_data,
	output logic                              out_valid,
	input  wire logic                         out_ready,
	output logic [W-1:0]                      out_data,
	output logic [$clog2(DEPTH+1)-1:0]        count
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	if (DEPTH < 2) begin : g_bad_depth
		$error("sfp_buf: DEPTH must be at least 2");
	end

	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	logic          push;
	logic          pop;

	function automatic logic [AW-1:0] next_idx(input logic [AW-1:0] idx);
		next_idx = (idx == AW'(DEPTH - 1)) ? '0 : idx + AW'(1);
	endfunction

	assign in_ready  = (cnt_q != CW'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign count     = cnt_q;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= next_idx(wr_q);
			end
			if (pop) begin
				rd_q <= next_idx(rd_q);
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + CW'(1);
			end else if (pop && !push) begin
				cnt_q <= cnt_q - CW'(1);
			end
		end
	end
endmodule

// ==========================================================
// Device end
module sfp_device
	import sfp_pkg::*;
#(
	parameter int HALF_CYC = IFACE_HALF_CYC,
	parameter int DEPTH    = BUF_DEPTH
) (
	// Clock and reset
	input  wire logic                 MCLK,
	input  wire logic                 SRST,
	// Mode control
	input  wire logic                 NV_PORT_A_FIFO,
	input  wire logic                 MODE_CMD,
	input  wire logic                 MODE_CMD_CHAN,
	input  wire logic                 MODE_EXIT,
	output logic                      SYNC_ACTIVE,
	output logic                      CHAN_B_AVAIL,
	// Bytes bound for the controller
	input  wire logic                 RX_VALID,
	output logic                      RX_READY,
	input  wire logic [BUS_W-1:0]     RX_DATA,
	// Bytes from the controller
	output logic                      TX_VALID,
	input  wire logic                 TX_READY,
	output logic [BUS_W-1:0]          TX_DATA,
	// Power state and send-immediate events
	input  wire logic                 USB_POWERED_N,
	output logic                      SEND_NOW,
	output logic                      WAKE_REQ,
	// Link
	sfp_if.dev                        lnk
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam int DW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;

	if (HALF_CYC < IFACE_HALF_MIN || HALF_CYC > 255) begin : g_bad_half
		$error("sfp_device: HALF_CYC out of range");
	end

	sfp_mode_t      mode_q;
	logic           active;
	logic [DW-1:0]  div_q;
	logic           clk_q;
	logic           rise;
	logic           rx_avail_n_q;
	logic           tx_space_n_q;
	logic           rx_pop;
	logic           tx_push;
	logic [CW-1:0]  rx_cnt;
	logic [CW-1:0]  tx_cnt;
	logic [CW-1:0]  rx_left;
	logic [CW:0]    tx_fill;
	logic           send_now_wake_prev_q;
	logic           send_now_q;
	logic           wake_q;
	logic           pwr_n_q;

	// ==========================================================
	// Mode entry, first channel only
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			mode_q <= MODE_OFF;
		end else begin
			unique case (mode_q)
				MODE_OFF: begin
					if (MODE_CMD && NV_PORT_A_FIFO && MODE_CMD_CHAN == CHAN_FIRST) begin
						mode_q <= MODE_SYNC;
					end
				end
				MODE_SYNC: begin
					// Losing the config also drops the mode
					if (MODE_EXIT || !NV_PORT_A_FIFO) begin
						mode_q <= MODE_OFF;
					end
				end
				default: mode_q <= MODE_OFF;
			endcase
		end
	end

	assign active       = (mode_q == MODE_SYNC);
	assign SYNC_ACTIVE  = active;
	assign CHAN_B_AVAIL = !active;

	// ==========================================================
	// Interface clock divider; rise marks the transfer edge
	assign rise = (div_q == DW'(HALF_CYC - 1)) && !clk_q;

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			div_q <= '0;
			clk_q <= 1'b0;
		end else if (div_q == DW'(HALF_CYC - 1)) begin
			div_q <= '0;
			clk_q <= !clk_q;
		end else begin
			div_q <= div_q + DW'(1);
		end
	end

	assign lnk.iface_clk = clk_q;

	// ==========================================================
	// Buffers on both data paths
	// Host pins follow our own divided clock, so they are sampled unsynchronised
	// A flag still low after mode exit honours one last transfer, as the host expects
	assign rx_pop  = rise && !rx_avail_n_q && !lnk.rd_n;
	assign tx_push = rise && !tx_space_n_q && !lnk.wr_n;

	sfp_buf #(.W(BUS_W), .DEPTH(DEPTH)) u_rx_buf (
		.clk       (MCLK),
		.rst       (SRST),
		.in_valid  (RX_VALID),
		.in_ready  (RX_READY),
		.in_data   (RX_DATA),
		.out_valid (),
		.out_ready (rx_pop),
		.out_data  (lnk.dev_dout),
		.count     (rx_cnt)
	);

	sfp_buf #(.W(BUS_W), .DEPTH(DEPTH)) u_tx_buf (
		.clk       (MCLK),
		.rst       (SRST),
		.in_valid  (tx_push),
		.in_ready  (),
		.in_data   (lnk.fifo_data_bus),
		.out_valid (TX_VALID),
		.out_ready (TX_READY),
		.out_data  (TX_DATA),
		.count     (tx_cnt)
	);

	// ==========================================================
	// Flags, moved only on rises
	// Refills between rises are not seen until the next rise; this keeps the flags synchronous
	assign rx_left = rx_cnt - CW'(rx_pop);
	assign tx_fill = {1'b0, tx_cnt} + (CW + 1)'(tx_push);

	// Mode exit also waits for a rise, so no flag moves between link edges
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			rx_avail_n_q <= PIN_IDLE;
		end else if (rise) begin
			rx_avail_n_q <= !active || (rx_left == '0);
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			tx_space_n_q <= PIN_IDLE;
		end else if (rise) begin
			tx_space_n_q <= !active || (tx_fill >= (CW + 1)'(DEPTH));
		end
	end

	assign lnk.rx_avail_n = rx_avail_n_q;
	assign lnk.tx_space_n = tx_space_n_q;
	assign lnk.dev_doe    = (active || !rx_avail_n_q) && !lnk.oe_n;

	// ==========================================================
	// Send-immediate and wake strobe
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			send_now_wake_prev_q <= PIN_IDLE;
			send_now_q  <= 1'b0;
			wake_q      <= 1'b0;
			pwr_n_q     <= PIN_IDLE;
		end else begin
			pwr_n_q    <= USB_POWERED_N;
			send_now_q <= 1'b0;
			wake_q     <= 1'b0;
			if (rise) begin
				send_now_wake_prev_q <= lnk.send_now_wake_n;
				if (send_now_wake_prev_q && !lnk.send_now_wake_n) begin
					send_now_q <= !pwr_n_q;
					wake_q     <= pwr_n_q;
				end
			end
		end
	end

	assign SEND_NOW             = send_now_q;
	assign WAKE_REQ             = wake_q;
	assign lnk.powered_config_n = pwr_n_q;

endmodule
`default_nettype wire

// *** rtl/sfp_host.sv ***
// Controller end of the synchronous byte FIFO port
`timescale 1ns/1ps
`default_nettype none
module sfp_host
	import sfp_pkg::*;
#(
	parameter int DEPTH = BUF_DEPTH
) (
	// Clock and reset
	input  wire logic                 MCLK,
	input  wire logic                 SRST,
	// Bytes read from the device
	output logic                      RD_VALID,
	input  wire logic                 RD_READY,
	output logic [BUS_W-1:0]          RD_DATA,
	// Bytes to write to the device
	input  wire logic                 WR_VALID,
	output logic                      WR_READY,
	input  wire logic [BUS_W-1:0]     WR_DATA,
	// Send-immediate request and power state
	input  wire logic                 SEND_NOW,
	output logic                      LINK_POWERED,
	// Link
	sfp_if.host                       lnk
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam int SW = BUS_W + 4;

	sfp_hstate_t     st_q;
	logic [SW-1:0]   pins;
	logic [SW-1:0]   s1_q;
	logic [SW-1:0]   s2_q;
	logic [SW-1:0]   s3_q;
	logic            clk_lvl_q;
	logic            rise;
	logic            fall;
	logic            rxf_l_q;
	logic            txe_l_q;
	logic            pwr_l_q;
	logic [BUS_W-1:0] din_l_q;
	logic            rd_xfer;
	logic            wr_xfer;
	logic [CW:0]     r_fill;
	logic [CW-1:0]   w_left;
	logic            rx_ok;
	logic            tx_ok;
	logic [CW-1:0]   r_cnt;
	logic [CW-1:0]   w_cnt;
	logic            pend_q;
	logic            send_now_wake_n_q;

	// ==========================================================
	// Three-stage sampling of device pins
	assign pins = {lnk.fifo_data_bus, lnk.powered_config_n, lnk.tx_space_n,
		lnk.rx_avail_n, lnk.iface_clk};

	always_ff @(posedge MCLK) begin
		s1_q <= pins;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end

	assign rise = s2_q[0] && s3_q[0] && !clk_lvl_q;
	assign fall = !s2_q[0] && !s3_q[0] && clk_lvl_q;

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			clk_lvl_q <= 1'b0;
		end else if (s2_q[0] == s3_q[0]) begin
			clk_lvl_q <= s3_q[0];
		end
	end

	// Mid-period sample holds what the device launched at the last rise
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			rxf_l_q <= PIN_IDLE;
			txe_l_q <= PIN_IDLE;
			pwr_l_q <= PIN_IDLE;
			din_l_q <= '0;
		end else if (fall) begin
			rxf_l_q <= s3_q[1];
			txe_l_q <= s3_q[2];
			pwr_l_q <= s3_q[3];
			din_l_q <= s3_q[SW-1:4];
		end
	end

	assign LINK_POWERED = !pwr_l_q;

	// ==========================================================
	// Transfers at each rise
	assign rd_xfer = rise && (st_q == HS_READ) && !rxf_l_q;
	assign wr_xfer = rise && (st_q == HS_WRITE) && !txe_l_q;

	sfp_buf #(.W(BUS_W), .DEPTH(DEPTH)) u_rd_buf (
		.clk       (MCLK),
		.rst       (SRST),
		.in_valid  (rd_xfer),
		.in_ready  (),
		.in_data   (din_l_q),
		.out_valid (RD_VALID),
		.out_ready (RD_READY),
		.out_data  (RD_DATA),
		.count     (r_cnt)
	);

	sfp_buf #(.W(BUS_W), .DEPTH(DEPTH)) u_wr_buf (
		.clk       (MCLK),
		.rst       (SRST),
		.in_valid  (WR_VALID),
		.in_ready  (WR_READY),
		.in_data   (WR_DATA),
		.out_valid (),
		.out_ready (wr_xfer),
		.out_data  (lnk.host_dout),
		.count     (w_cnt)
	);

	assign r_fill = {1'b0, r_cnt} + (CW + 1)'(rd_xfer);
	assign w_left = w_cnt - CW'(wr_xfer);
	// Read only with room for the next byte, so a stalled reader loses nothing
	assign rx_ok  = !rxf_l_q && (r_fill < (CW + 1)'(DEPTH));
	assign tx_ok  = !txe_l_q && (w_left != '0);

	// ==========================================================
	// Strobe sequencing; reads take priority
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			st_q <= HS_IDLE;
		end else if (rise) begin
			unique case (st_q)
				HS_IDLE: begin
					if (rx_ok) begin
						st_q <= HS_TURN;
					end else if (tx_ok) begin
						st_q <= HS_WRITE;
					end
				end
				HS_TURN: st_q <= rx_ok ? HS_READ : HS_IDLE;
				HS_READ: st_q <= rx_ok ? HS_READ : HS_IDLE;
				HS_WRITE: begin
					if (!rxf_l_q || !tx_ok) begin
						st_q <= HS_IDLE;
					end
				end
				default: st_q <= HS_IDLE;
			endcase
		end
	end

	assign lnk.oe_n     = !(st_q == HS_TURN || st_q == HS_READ);
	assign lnk.rd_n     = (st_q != HS_READ);
	assign lnk.wr_n     = (st_q != HS_WRITE);
	assign lnk.host_doe = (st_q == HS_WRITE) && lnk.oe_n;

	// ==========================================================
	// Send-immediate strobe, held low for one interface period
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			pend_q   <= 1'b0;
			send_now_wake_n_q <= PIN_IDLE;
		end else begin
			if (SEND_NOW) begin
				pend_q <= 1'b1;
			end else if (rise) begin
				pend_q <= 1'b0;
			end
			if (rise) begin
				send_now_wake_n_q <= !pend_q;
			end
		end
	end

	assign lnk.send_now_wake_n = send_now_wake_n_q;

endmodule
`default_nettype wire

// *** test/sfp_sva.sv ***
// Concurrent checks on the link between device end and controller end
`timescale 1ns/1ps
`default_nettype none
module sfp_sva
	import sfp_pkg::*;
#(
	parameter int HALF_CYC = IFACE_HALF_CYC
) (
	// Clock and reset
	input  wire logic             MCLK,
	input  wire logic             SRST,
	// Link
	input  wire logic             iface_clk,
	input  wire logic             rx_avail_n,
	input  wire logic             tx_space_n,
	input  wire logic             rd_n,
	input  wire logic             wr_n,
	input  wire logic             oe_n,
	input  wire logic [BUS_W-1:0] dev_dout,
	input  wire logic             dev_doe,
	input  wire logic             host_doe
);
	// Host leaves a transfer one full link period (sampling half plus next half) plus its synchroniser after a flag rises
	localparam int LEAVE = 3 * HALF_CYC;

	default clocking @(posedge MCLK); endclocking
	default disable iff (SRST);

	// ==========================================================
	// Half-period counter of the link clock
	logic       clk_q;
	logic       seen_q;
	logic [7:0] run_q;
	always_ff @(posedge MCLK) begin
		clk_q <= iface_clk;
		if (SRST || iface_clk != clk_q)
			run_q <= 8'h00;
		else
			run_q <= run_q + 8'h01;
	end
	always_ff @(posedge MCLK) begin
		if (SRST)
			seen_q <= 1'b0;
		else if (iface_clk != clk_q)
			seen_q <= 1'b1;
	end

	// ==========================================================
	// Steps of a read turn-around
	sequence s_turned;
		!oe_n && $past(oe_n, 2 * HALF_CYC - 1) == 1'b0;
	endsequence

	sequence s_rd_start;
		$fell(rd_n);
	endsequence

	a_clk_half: assert property (seen_q && iface_clk != clk_q |-> run_q == 8'(HALF_CYC - 1))
		else $error("link clock half period wrong");
	a_rx_edge: assert property ($changed(rx_avail_n) |-> $rose(iface_clk))
		else $error("receive flag moved off a link clock rise");
	a_tx_edge: assert property ($changed(tx_space_n) |-> $rose(iface_clk))
		else $error("transmit flag moved off a link clock rise");
	a_oe_before_rd: assert property (s_rd_start |-> s_turned)
		else $error("read strobe without a full output enable period");
	a_head_hold: assert property (!rx_avail_n && $past(rx_avail_n) == 1'b0 && !$rose(iface_clk)
		|-> $stable(dev_dout))
		else $error("head byte changed between link clock rises");
	a_rx_leave: assert property ($rose(rx_avail_n) |-> ##[0:LEAVE] rd_n)
		else $error("read strobe held after receive flag rose");
	a_tx_leave: assert property ($rose(tx_space_n) |-> ##[0:LEAVE] wr_n)
		else $error("write strobe held after transmit flag rose");
	a_wr_drive: assert property (!wr_n |-> host_doe && oe_n)
		else $error("write strobe without controller bus drive");
	a_dev_drive: assert property (dev_doe |-> !oe_n)
		else $error("device drives bus while output enable high");
	a_host_quiet: assert property (!oe_n |-> !host_doe)
		else $error("controller drives bus while output enable low");

	c_read: cover property (s_rd_start);
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench: device end and controller end joined through the link
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sfp_pkg::*;

	localparam int HALF = IFACE_HALF_CYC;

	// ==========================================================
	// Signals
	logic       mclk, srst, nv, cmd, chan, ext, sync_active, chan_b, pwr_n, dev_now, wake_req;
	logic       rxv, rx_ready, tx_valid, txr, rd_valid, rdr, wrv, wr_ready, snow, link_powered;
	logic [7:0] rxd, tx_data, rd_data, wrd;
	logic       rx_go, wr_go;
	logic [7:0] rx_exp[$];
	logic [7:0] wr_exp[$];
	logic       stall = 1'b0;
	int         rx_left = 0;
	int         wr_left = 0;
	int         failures = 0;
	int         num_checks = 0;

	sfp_if lnk ();
	sfp_device #(.HALF_CYC(HALF)) sfp_device_i (
		.MCLK(mclk), .SRST(srst), .NV_PORT_A_FIFO(nv), .MODE_CMD(cmd), .MODE_CMD_CHAN(chan),
		.MODE_EXIT(ext), .SYNC_ACTIVE(sync_active), .CHAN_B_AVAIL(chan_b), .RX_VALID(rxv),
		.RX_READY(rx_ready), .RX_DATA(rxd), .TX_VALID(tx_valid), .TX_READY(txr),
		.TX_DATA(tx_data), .USB_POWERED_N(pwr_n), .SEND_NOW(dev_now), .WAKE_REQ(wake_req),
		.lnk(lnk.dev));
	sfp_host sfp_host_i (
		.MCLK(mclk), .SRST(srst), .RD_VALID(rd_valid), .RD_READY(rdr), .RD_DATA(rd_data),
		.WR_VALID(wrv), .WR_READY(wr_ready), .WR_DATA(wrd), .SEND_NOW(snow),
		.LINK_POWERED(link_powered), .lnk(lnk.host));
	sfp_sva #(.HALF_CYC(HALF)) sfp_sva_i (
		.MCLK(mclk), .SRST(srst), .iface_clk(lnk.iface_clk), .rx_avail_n(lnk.rx_avail_n),
		.tx_space_n(lnk.tx_space_n), .rd_n(lnk.rd_n), .wr_n(lnk.wr_n), .oe_n(lnk.oe_n),
		.dev_dout(lnk.dev_dout), .dev_doe(lnk.dev_doe), .host_doe(lnk.host_doe));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// ==========================================================
	// Expectations and reporting
	function automatic logic exp_mode(input logic nvs, input logic ch);
		return nvs && !ch;
	endfunction

	function automatic logic [7:0] exp_pulse(input logic hit);
		return {7'h00, hit};
	endfunction

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic drain();
		int k;
		for (k = 0; k < 30000; k++) begin
			@(posedge mclk);
			if (rx_left + wr_left == 0 && !rxv && !wrv && rx_exp.size() + wr_exp.size() == 0)
				break;
		end
		if (k == 30000) begin
			failures++;
			$display("[ERR] drain expected idle seen busy");
			test_done();
		end
	endtask

	// ==========================================================
	// Random sources; a held offer keeps its byte until taken
	always @(posedge mclk) begin
		if (rxv && rx_ready)
			rx_exp.push_back(rxd);
		if (wrv && wr_ready)
			wr_exp.push_back(wrd);
		// Count one byte per offer made, so a scenario sends exactly its quota
		if (!rxv || rx_ready) begin
			rx_go = rx_left > 0 && $urandom % 4 != 0;
			rxd <= 8'($urandom);
			rxv <= rx_go;
			if (rx_go)
				rx_left <= rx_left - 1;
		end
		if (!wrv || wr_ready) begin
			wr_go = wr_left > 0 && $urandom % 4 != 0;
			wrd <= 8'($urandom);
			wrv <= wr_go;
			if (wr_go)
				wr_left <= wr_left - 1;
		end
	end

	// Sinks stall at random; byte order must survive every stall
	always @(posedge mclk) begin
		if (rd_valid && rdr)
			check("rd_data", rd_data, rx_exp.pop_front());
		if (tx_valid && txr)
			check("tx_data", tx_data, wr_exp.pop_front());
		rdr <= !stall && $urandom % 3 != 0;
		txr <= !stall && $urandom % 3 != 0;
	end

	initial begin
		repeat (100000) @(posedge mclk);
		failures++;
		$display("[ERR] run expected end seen timeout");
		test_done();
	end

	// ==========================================================
	// Main sequence
	initial begin
		logic [7:0] sn;
		logic [7:0] wk;
		{nv, cmd, chan, ext, rxv, txr, rdr, wrv, snow, rxd, wrd} = '0;
		pwr_n = 1'b1;
		srst = 1'b1;
		sn = 8'($urandom(12));
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		check("chan_b", chan_b, 1'b1);
		// Offers before the mode must sit unread
		rx_left <= 2;
		repeat (300) @(posedge mclk);
		check("rd_valid", rd_valid, 1'b0);
		// Refused commands first, the accepted one last
		for (int i = 0; i < 4; i++) begin
			nv <= i[1];
			chan <= i[0] ^ i[1];
			cmd <= 1'b1;
			@(posedge mclk);
			cmd <= 1'b0;
			repeat (2) @(posedge mclk);
			check("sync_active", sync_active, exp_mode(i[1], i[0] ^ i[1]));
			check("chan_b", chan_b, !exp_mode(i[1], i[0] ^ i[1]));
		end
		rx_left <= 40;
		wr_left <= 40;
		drain();
		// Stalled sinks fill both paths until refused
		stall <= 1'b1;
		rx_left <= 12;
		wr_left <= 12;
		repeat (1500) @(posedge mclk);
		check("rx_ready", rx_ready, 1'b0);
		check("wr_ready", wr_ready, 1'b0);
		check("rx_avail_n", lnk.rx_avail_n, 1'b0);
		check("tx_space_n", lnk.tx_space_n, 1'b1);
		stall <= 1'b0;
		drain();
		repeat (4 * HALF) @(posedge mclk);
		check("rx_avail_n", lnk.rx_avail_n, 1'b1);
		check("tx_space_n", lnk.tx_space_n, 1'b0);
		// Send-immediate while powered, wake request while not
		for (int p = 0; p < 2; p++) begin
			pwr_n <= p[0];
			repeat (40) @(posedge mclk);
			check("link_powered", link_powered, !p[0]);
			snow <= 1'b1;
			@(posedge mclk);
			snow <= 1'b0;
			sn = 8'h00;
			wk = 8'h00;
			repeat (100) begin
				@(posedge mclk);
				sn = sn + {7'h00, dev_now};
				wk = wk + {7'h00, wake_req};
			end
			check("send_now", sn, exp_pulse(!p[0]));
			check("wake_req", wk, exp_pulse(p[0]));
		end
		ext <= 1'b1;
		@(posedge mclk);
		ext <= 1'b0;
		repeat (2) @(posedge mclk);
		check("sync_active", sync_active, 1'b0);
		check("chan_b", chan_b, 1'b1);
		// Dropping the config also leaves the mode
		cmd <= 1'b1;
		@(posedge mclk);
		cmd <= 1'b0;
		repeat (20) @(posedge mclk);
		check("sync_active", sync_active, 1'b1);
		nv <= 1'b0;
		repeat (2) @(posedge mclk);
		check("sync_active", sync_active, 1'b0);
		check("chan_b", chan_b, 1'b1);
		test_done();
	end
endmodule
`default_nettype wire
